// ==== common/isf_pkg.sv ====
package isf_pkg;

	// ************************************************************
	// Register map (byte offsets on the plain register port)
	// ************************************************************
	localparam int ADDR_W = 3;
	localparam logic [2:0] ADDR_CTRL = 3'h0;
	localparam logic [2:0] ADDR_STAT1 = 3'h1;
	localparam logic [2:0] ADDR_STAT2 = 3'h2;
	localparam logic [2:0] ADDR_DATA = 3'h3;

	// ************************************************************
	// Control register field positions
	// ************************************************************
	localparam int CTRL_ITE = 0;
	localparam int CTRL_STOP = 1;
	localparam int CTRL_ACK = 2;
	localparam int CTRL_START = 3;
	localparam int CTRL_GENERAL_CALL_ENABLE = 4;
	localparam int CTRL_PE = 5;

	// ************************************************************
	// Status field positions
	// ************************************************************
	localparam int S1_SB = 0;
	localparam int S1_MSL = 1;
	localparam int S1_OWN_ADDRESS_HIT = 2;
	localparam int S1_BTF = 3;
	localparam int S1_BUSY = 4;
	localparam int S1_TRA = 5;
	localparam int S1_TEN_BIT_HEADER_SENT = 6;
	localparam int S1_EVF = 7;
	localparam int S2_GENERAL_CALL_SEEN = 0;
	localparam int S2_BUS_ERROR = 1;
	localparam int S2_ARBITRATION_LOST = 2;
	localparam int S2_STOP_SEEN = 3;
	localparam int S2_AF = 4;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] STAT2_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [7:0] RDATA_RST = 8'h00;
	localparam logic [2:0] PIN_SYNC_RST = 3'h7;

	// Event pulses from the byte engine, same clock domain
	typedef struct packed {
		logic byte_tx;
		logic byte_rx;
		logic addr_match;
		logic gen_call;
		logic start_gen;
		logic no_ack;
		logic arb_lost;
		logic misplaced;
		logic hdr10_sent;
		logic maddr_sent;
		logic [7:0] rx_byte;
	} isf_evt_t;

	// One register port request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} isf_req_t;

endpackage

// ==== hdl/isf_status_flags.sv ====
`timescale 1ns/1ps
module isf_status_flags
	import isf_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// Register port
	input wire isf_req_t req,
	output logic [7:0] rdata,
	// Byte engine
	input wire isf_evt_t evt,
	output logic start_req_o,
	output logic stop_req_o,
	output logic ack_en_o,
	output logic pe_o,
	output logic [7:0] tx_data_o,
	output logic tx_load_o,
	// Bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic scl_oe,
	// Interrupt
	input wire logic global_mask,
	output logic irq_o
);

	// ************************************************************
	// Declarations
	// ************************************************************
	logic [2:0] scl_s_q;
	logic [2:0] sda_s_q;
	logic scl_f_q, sda_f_q, scl_p_q, sda_p_q;
	logic start_det, stop_det;
	logic pe_q, general_call_enable_q, start_q, ack_q, stop_q, ite_q;
	logic btf_q, tra_q, own_address_hit_q, msl_q, sb_q, ten_bit_header_sent_q, ev6_q, busy_q;
	logic af_q, stop_seen_q, arbitration_lost_q, bus_error_q, general_call_seen_q, acked_q;
	logic s1_arm_q, s2_arm_q;
	logic [7:0] dr_q;
	logic [7:0] rdata_q;
	logic wr_ctrl, rd_s1, rd_s2, rd_dr, wr_dr, any_acc;
	logic event_flag, errs, hold;
	logic [7:0] sr1_v, sr2_v, ctrl_v;

	// ************************************************************
	// Pin sampling and start/stop detection
	// ************************************************************

	// Three stages; a level counts once the last two agree
	always_ff @(posedge clk) begin
		if (srst) begin
			scl_s_q <= PIN_SYNC_RST;
			sda_s_q <= PIN_SYNC_RST;
		end else if (ce) begin
			scl_s_q <= {scl_s_q[1:0], scl_i};
			sda_s_q <= {sda_s_q[1:0], sda_i};
		end
	end

	// Filtered levels and their previous values; idle bus is high
	always_ff @(posedge clk) begin
		if (srst) begin
			scl_f_q <= 1'b1;
			sda_f_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else if (ce) begin
			if (scl_s_q[1] == scl_s_q[2]) begin
				scl_f_q <= scl_s_q[2];
			end
			if (sda_s_q[1] == sda_s_q[2]) begin
				sda_f_q <= sda_s_q[2];
			end
			scl_p_q <= scl_f_q;
			sda_p_q <= sda_f_q;
		end
	end

	// Data edge while clock stays high marks start or stop
	assign start_det = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
	assign stop_det = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;

	// ************************************************************
	// Register port decode and access sequencing
	// ************************************************************
	assign wr_ctrl = ce & req.wr & (req.addr == ADDR_CTRL);
	assign rd_s1 = ce & req.rd & (req.addr == ADDR_STAT1);
	assign rd_s2 = ce & req.rd & (req.addr == ADDR_STAT2);
	assign rd_dr = ce & req.rd & (req.addr == ADDR_DATA);
	assign wr_dr = ce & req.wr & (req.addr == ADDR_DATA);
	assign any_acc = ce & (req.rd | req.wr);

	// A status read arms the next access only; anything else disarms.
	// A byte, start, header or address-sent event with no access in its cycle also disarms: a read taken
	// in an earlier cycle must not let a later data access clear it unseen.
	always_ff @(posedge clk) begin
		if (srst) begin
			s1_arm_q <= 1'b0;
			s2_arm_q <= 1'b0;
		end else if (any_acc) begin
			s1_arm_q <= rd_s1;
			s2_arm_q <= rd_s2;
		end else if (ce && (evt.byte_tx || evt.byte_rx || evt.start_gen
			|| evt.hdr10_sent || evt.maddr_sent)) begin
			s1_arm_q <= 1'b0;
			s2_arm_q <= 1'b0;
		end
	end

	// ************************************************************
	// Control register
	// ************************************************************

	// First write while disabled only sets the enable, so a stale
	// image cannot launch a start before the pins are handed over
	always_ff @(posedge clk) begin
		if (srst) begin
			{pe_q, general_call_enable_q, start_q, ack_q, stop_q, ite_q} <= 6'h00;
		end else if (ce) begin
			if (wr_ctrl) begin
				pe_q <= req.wdata[CTRL_PE];
				if (pe_q) begin
					general_call_enable_q <= req.wdata[CTRL_GENERAL_CALL_ENABLE];
					start_q <= req.wdata[CTRL_START];
					ack_q <= req.wdata[CTRL_ACK];
					stop_q <= req.wdata[CTRL_STOP];
					ite_q <= req.wdata[CTRL_ITE];
				end
			end
			if (evt.start_gen) begin
				start_q <= 1'b0;
			end
			if (stop_det && msl_q) begin
				stop_q <= 1'b0;
			end
			// Stop request survives disable
			if (!pe_q) begin
				{general_call_enable_q, start_q, ack_q, ite_q} <= 4'h0;
			end
		end
	end

	// ************************************************************
	// Data register
	// ************************************************************

	// Received byte lands after a same-cycle software write
	always_ff @(posedge clk) begin
		if (srst) begin
			dr_q <= DATA_RST;
		end else if (ce) begin
			if (wr_dr) begin
				dr_q <= req.wdata;
			end
			if (evt.byte_rx && pe_q) begin
				dr_q <= evt.rx_byte;
			end
		end
	end

	// ************************************************************
	// Status one flags
	// ************************************************************

	// Bus activity is followed regardless of enable
	always_ff @(posedge clk) begin
		if (srst) begin
			busy_q <= 1'b0;
		end else if (ce) begin
			if (stop_det) begin
				busy_q <= 1'b0;
			end
			if (start_det) begin
				busy_q <= 1'b1;
			end
		end
	end

	// Byte finished; set wins over the clearing data access
	always_ff @(posedge clk) begin
		if (srst) begin
			btf_q <= 1'b0;
		end else if (ce) begin
			if (!pe_q) begin
				btf_q <= 1'b0;
			end else begin
				if (s1_arm_q && (rd_dr || wr_dr)) begin
					btf_q <= 1'b0;
				end
				if (evt.byte_tx) begin
					btf_q <= 1'b1;
				end
				if (evt.byte_rx) begin
					btf_q <= 1'b1;
				end
			end
		end
	end

	// Direction of the last finished byte
	always_ff @(posedge clk) begin
		if (srst) begin
			tra_q <= 1'b0;
		end else if (ce) begin
			if (!pe_q || stop_det || evt.arb_lost) begin
				tra_q <= 1'b0;
			end else begin
				if (s1_arm_q && (rd_dr || wr_dr)) begin
					tra_q <= 1'b0;
				end
				if (evt.byte_rx) begin
					tra_q <= 1'b0;
				end
				if (evt.byte_tx) begin
					tra_q <= 1'b1;
				end
			end
		end
	end

	// Address hit, plain or general call
	always_ff @(posedge clk) begin
		if (srst) begin
			own_address_hit_q <= 1'b0;
		end else if (ce) begin
			if (!pe_q) begin
				own_address_hit_q <= 1'b0;
			end else begin
				if (rd_s1) begin
					own_address_hit_q <= 1'b0;
				end
				if (evt.addr_match || (evt.gen_call && general_call_enable_q)) begin
					own_address_hit_q <= 1'b1;
				end
			end
		end
	end

	// Master mode; a start request in the loss cycle wins
	always_ff @(posedge clk) begin
		if (srst) begin
			msl_q <= 1'b0;
		end else if (ce) begin
			if (!pe_q) begin
				msl_q <= 1'b0;
			end else begin
				if (stop_det || evt.arb_lost) begin
					msl_q <= 1'b0;
				end
				if (wr_ctrl && req.wdata[CTRL_START]) begin
					msl_q <= 1'b1;
				end
			end
		end
	end

	// Start sent, header sent and master address sent events
	always_ff @(posedge clk) begin
		if (srst) begin
			sb_q <= 1'b0;
			ten_bit_header_sent_q <= 1'b0;
			ev6_q <= 1'b0;
		end else if (ce) begin
			if (!pe_q) begin
				{sb_q, ten_bit_header_sent_q, ev6_q} <= 3'h0;
			end else begin
				if (s1_arm_q && wr_dr) begin
					sb_q <= 1'b0;
				end
				if (s2_arm_q && wr_dr) begin
					ten_bit_header_sent_q <= 1'b0;
				end
				if (s1_arm_q && wr_ctrl) begin
					ev6_q <= 1'b0;
				end
				if (evt.start_gen && start_q) begin
					sb_q <= 1'b1;
				end
				if (evt.hdr10_sent) begin
					ten_bit_header_sent_q <= 1'b1;
				end
				if (evt.maddr_sent) begin
					ev6_q <= 1'b1;
				end
			end
		end
	end

	// ************************************************************
	// Status two flags
	// ************************************************************

	// Remembers an acknowledge we gave since the last start or stop
	always_ff @(posedge clk) begin
		if (srst) begin
			acked_q <= 1'b0;
		end else if (ce) begin
			if (start_det || stop_det || !pe_q) begin
				acked_q <= 1'b0;
			end
			if ((evt.addr_match || evt.byte_rx) && ack_q) begin
				acked_q <= 1'b1;
			end
		end
	end

	// Error flags clear on a status_two read; a new event wins
	always_ff @(posedge clk) begin
		if (srst) begin
			{af_q, stop_seen_q, arbitration_lost_q, bus_error_q} <= 4'h0;
		end else if (ce) begin
			if (!pe_q) begin
				{af_q, stop_seen_q, arbitration_lost_q, bus_error_q} <= 4'h0;
			end else begin
				if (rd_s2) begin
					{af_q, stop_seen_q, arbitration_lost_q, bus_error_q} <= 4'h0;
				end
				if (evt.no_ack) begin
					af_q <= 1'b1;
				end
				if (stop_det && acked_q && ack_q && !msl_q) begin
					stop_seen_q <= 1'b1;
				end
				if (evt.arb_lost) begin
					arbitration_lost_q <= 1'b1;
				end
				if (evt.misplaced) begin
					bus_error_q <= 1'b1;
				end
			end
		end
	end

	// General call, cleared by hardware only
	always_ff @(posedge clk) begin
		if (srst) begin
			general_call_seen_q <= 1'b0;
		end else if (ce) begin
			if (!pe_q || stop_det) begin
				general_call_seen_q <= 1'b0;
			end else if (evt.gen_call && general_call_enable_q) begin
				general_call_seen_q <= 1'b1;
			end
		end
	end

	// ************************************************************
	// Summary, clock hold, interrupt, outputs
	// ************************************************************
	assign errs = af_q | stop_seen_q | arbitration_lost_q | bus_error_q;
	assign event_flag = btf_q | own_address_hit_q | sb_q | errs | ten_bit_header_sent_q | ev6_q;
	// Error flags release the clock so software can recover the bus
	assign hold = pe_q & (btf_q | own_address_hit_q | sb_q | ten_bit_header_sent_q | ev6_q)
		& ~errs;
	assign scl_o = 1'b0;
	assign scl_oe = hold;
	assign irq_o = event_flag & ite_q & ~global_mask;
	assign ack_en_o = ack_q & pe_q;
	assign start_req_o = start_q;
	assign stop_req_o = stop_q;
	assign pe_o = pe_q;
	assign tx_data_o = dr_q;
	assign tx_load_o = wr_dr & pe_q;

	// Register images
	assign sr1_v = {event_flag, ten_bit_header_sent_q, tra_q, busy_q, btf_q, own_address_hit_q, msl_q,
		sb_q};
	assign sr2_v = {3'h0, af_q, stop_seen_q, arbitration_lost_q, bus_error_q, general_call_seen_q};
	assign ctrl_v = {2'h0, pe_q, general_call_enable_q, start_q, ack_q, stop_q, ite_q};

	// Read data stands one cycle after the strobe only
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_q <= RDATA_RST;
		end else if (ce) begin
			rdata_q <= RDATA_RST;
			if (req.rd) begin
				unique case (req.addr)
					ADDR_CTRL: rdata_q <= ctrl_v;
					ADDR_STAT1: rdata_q <= sr1_v;
					ADDR_STAT2: rdata_q <= sr2_v;
					ADDR_DATA: rdata_q <= dr_q;
					default: rdata_q <= RDATA_RST;
				endcase
			end
		end
	end
	assign rdata = rdata_q;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_sr1_rd;
		rd_s1;
	endsequence
	sequence s_sr2_rd;
		rd_s2;
	endsequence
	sequence s_dr_acc;
		(rd_dr || wr_dr) && !evt.byte_tx && !evt.byte_rx;
	endsequence

	property p_btf_clear;
		s_sr1_rd ##1 s_dr_acc |=> !btf_q;
	endproperty
	a_btf_clear: assert property (p_btf_clear)
		else $error("byte flag not cleared by access sequence");

	property p_sb_clear;
		s_sr1_rd ##1 (wr_dr && !evt.start_gen) |=> !sb_q;
	endproperty
	a_sb_clear: assert property (p_sb_clear)
		else $error("start flag not cleared by access sequence");

	property p_ten_bit_header_sent_clear;
		s_sr2_rd ##1 (wr_dr && !evt.hdr10_sent) |=> !ten_bit_header_sent_q;
	endproperty
	a_ten_bit_header_sent_clear: assert property (p_ten_bit_header_sent_clear)
		else $error("header flag not cleared by access sequence");

	property p_own_address_hit_clear;
		rd_s1 && !evt.addr_match && !evt.gen_call |=> !own_address_hit_q;
	endproperty
	a_own_address_hit_clear: assert property (p_own_address_hit_clear)
		else $error("address hit not cleared by status read");

	property p_err_clear;
		rd_s2 && !evt.no_ack && !evt.arb_lost && !evt.misplaced && !stop_det
			|=> !af_q && !arbitration_lost_q && !bus_error_q && !stop_seen_q;
	endproperty
	a_err_clear: assert property (p_err_clear)
		else $error("error flags not cleared by status_two read");

	property p_busy;
		ce && start_det |=> busy_q ##1 (busy_q || $past(stop_det));
	endproperty
	a_busy: assert property (p_busy)
		else $error("busy flag not tracking start");

	property p_pe_off;
		ce && !pe_q |=> ((sr1_v & ~(8'h01 << S1_BUSY)) == 8'h00)
			&& (sr2_v == 8'h00);
	endproperty
	a_pe_off: assert property (p_pe_off)
		else $error("flags not cleared while disabled");

	property p_no_hold_err;
		errs |-> !scl_oe;
	endproperty
	a_no_hold_err: assert property (p_no_hold_err)
		else $error("clock held while error flag set");

	property p_hold;
		pe_q && (btf_q || own_address_hit_q) && !errs |-> scl_oe && !scl_o;
	endproperty
	a_hold: assert property (p_hold)
		else $error("clock not held during byte or address event");

	property p_arbitration_lost;
		ce && pe_q && evt.arb_lost && !req.wr |=> arbitration_lost_q && !msl_q && !tra_q
			&& event_flag;
	endproperty
	a_arbitration_lost: assert property (p_arbitration_lost)
		else $error("arbitration loss not handled");

	property p_irq;
		irq_o == (event_flag && ite_q && !global_mask);
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt request mismatch");

	property p_sr2_rsv;
		ce && rd_s2 |=> rdata[7:5] == 3'h0 && rdata[S2_AF] == $past(af_q);
	endproperty
	a_sr2_rsv: assert property (p_sr2_rsv)
		else $error("status_two read value wrong");

	property p_general_call_seen;
		ce && stop_det |=> !general_call_seen_q;
	endproperty
	a_general_call_seen: assert property (p_general_call_seen)
		else $error("general call flag survived a stop");

endmodule // isf_status_flags

// ==== test/isf_bus_partner.sv ====
`timescale 1ns/1ps
// ************************************************************
// Remote master on the two-wire bus, open drain with pull-ups
// ************************************************************
module isf_bus_partner (
	// Device side of the clock line
	input wire logic scl_o,
	input wire logic scl_oe,
	// Resolved lines
	output logic scl,
	output logic sda
);
	logic scl_low;
	logic sda_low;

	// Both lines released at time zero: the bus idles high
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end

	// Pull-ups: a line is high unless some party pulls it down
	assign scl = !(scl_low || (scl_oe && !scl_o));
	assign sda = !sda_low;

	// Release the clock and wait out stretching, bounded so a stuck hold
	// cannot hang the frame
	task automatic rise_scl();
		int n;
		n = 0;
		scl_low = 1'b0;
		while (!scl && n < 200) begin
			#100;
			n++;
		end
		#400;
	endtask

	// Start: data falls while the clock is high
	task automatic bus_start();
		sda_low = 1'b1;
		#400;
		scl_low = 1'b1;
		#400;
	endtask

	// 800 ns clock only inside a frame; data moves while clock is low
	task automatic pulses(input int k);
		repeat (k) begin
			sda_low = !sda_low;
			rise_scl();
			scl_low = 1'b1;
			#400;
		end
	endtask

	// Stop: data rises while the clock is high; clock then stands still
	task automatic bus_stop();
		sda_low = 1'b1;
		#400;
		rise_scl();
		sda_low = 1'b0;
		#1200;
	endtask
endmodule // isf_bus_partner

// ==== test/tb_isf_status_flags.sv ====
`timescale 1ns/1ps
module tb_isf_status_flags
	import isf_pkg::*;
;
	logic clk;
	logic srst;
	logic ce;
	isf_req_t req;
	isf_evt_t evt;
	logic global_mask;
	logic [7:0] rdata;
	logic start_req_o;
	logic stop_req_o;
	logic ack_en_o;
	logic pe_o;
	logic [7:0] tx_data_o;
	logic tx_load_o;
	logic scl_line;
	logic sda_line;
	logic scl_o;
	logic scl_oe;
	logic irq_o;
	int fail_count;
	int samples_checked;

	// ************************************************************
	// Instances
	// ************************************************************
	isf_status_flags isf_status_flags_inst (
		.clk(clk), .srst(srst), .ce(ce), .req(req), .rdata(rdata),
		.evt(evt), .start_req_o(start_req_o), .stop_req_o(stop_req_o),
		.ack_en_o(ack_en_o), .pe_o(pe_o), .tx_data_o(tx_data_o),
		.tx_load_o(tx_load_o), .scl_i(scl_line), .sda_i(sda_line),
		.scl_o(scl_o), .scl_oe(scl_oe), .global_mask(global_mask),
		.irq_o(irq_o)
	);
	isf_bus_partner isf_bus_partner_inst (
		.scl_o(scl_o), .scl_oe(scl_oe), .scl(scl_line), .sda(sda_line)
	);

	// 10 MHz clock
	always #50 clk = !clk;

	// ************************************************************
	// Checks and bus tasks
	// ************************************************************
	task automatic chk8(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("[ERR] %s exp %h got %h", nm, e, g);
			fail_count++;
		end
	endtask

	task automatic chk1(input string nm, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			$display("[ERR] %s exp %b got %b", nm, e, g);
			fail_count++;
		end
	endtask

	task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req <= '0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] e,
		input string nm);
		@(posedge clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req <= '0;
		@(negedge clk);
		chk8(nm, e, rdata);
	endtask

	// One-cycle event pulse; m is the ten event bits from byte_tx down
	task automatic pulse(input logic [9:0] m, input logic [7:0] b);
		@(posedge clk);
		evt <= isf_evt_t'({m, b});
		@(posedge clk);
		evt <= '0;
		@(negedge clk);
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Watchdog: the tests need well under a millisecond
	initial begin
		#3_000_000;
		fail_count++;
		stop_test();
	end

	// ************************************************************
	// Test sequence
	// ************************************************************
	initial begin
		clk = 1'b0;
		srst = 1'b1;
		ce = 1'b1;
		req = '0;
		evt = '0;
		global_mask = 1'b0;
		fail_count = 0;
		samples_checked = 0;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		// Reset values, unmapped offsets 4 and 5 included
		for (int a = 0; a < 6; a++) rd_chk(3'(a), 8'h00, "reset");
		$display("test reset done");
		// First enabling write only sets the enable bit
		bus_wr(ADDR_CTRL, 8'h35);
		rd_chk(ADDR_CTRL, 8'h20, "ctrl first");
		bus_wr(ADDR_CTRL, 8'h35);
		rd_chk(ADDR_CTRL, 8'h35, "ctrl");
		chk1("ack_en", 1'b1, ack_en_o);
		chk1("pe_o", 1'b1, pe_o);
		chk1("scl_o", 1'b0, scl_o);
		$display("test enable done");
		// Byte sent without acknowledge: error flag suppresses the hold
		pulse(10'h210, 8'h00);
		chk1("hold err", 1'b0, scl_oe);
		chk1("irq", 1'b1, irq_o);
		@(posedge clk);
		global_mask <= 1'b1;
		@(negedge clk);
		chk1("irq masked", 1'b0, irq_o);
		@(posedge clk);
		global_mask <= 1'b0;
		rd_chk(ADDR_STAT2, 8'h10, "sr2 af");
		chk1("hold btf", 1'b1, scl_oe);
		rd_chk(ADDR_STAT1, 8'ha8, "sr1 tx");
		bus_wr(ADDR_DATA, 8'h3c);
		rd_chk(ADDR_STAT1, 8'h00, "sr1 tx clr");
		chk1("hold off", 1'b0, scl_oe);
		chk8("tx_data", 8'h3c, tx_data_o);
		$display("test transmit done");
		// Received byte: a data read alone does not clear
		pulse(10'h100, 8'h5a);
		rd_chk(ADDR_DATA, 8'h5a, "dr rx");
		rd_chk(ADDR_STAT1, 8'h88, "sr1 rx");
		rd_chk(ADDR_DATA, 8'h5a, "dr rx");
		rd_chk(ADDR_STAT1, 8'h00, "sr1 rx clr");
		$display("test receive done");
		// Master start, then arbitration loss
		bus_wr(ADDR_CTRL, 8'h3d);
		rd_chk(ADDR_STAT1, 8'h02, "sr1 msl");
		chk1("start_req", 1'b1, start_req_o);
		pulse(10'h020, 8'h00);
		chk1("start_req clr", 1'b0, start_req_o);
		chk1("stop_req", 1'b0, stop_req_o);
		rd_chk(ADDR_STAT1, 8'h83, "sr1 sb");
		bus_wr(ADDR_DATA, 8'ha0);
		rd_chk(ADDR_STAT1, 8'h02, "sr1 sb clr");
		pulse(10'h008, 8'h00);
		chk1("hold arbitration_lost", 1'b0, scl_oe);
		rd_chk(ADDR_STAT1, 8'h80, "sr1 arbitration_lost");
		rd_chk(ADDR_STAT2, 8'h04, "sr2 arbitration_lost");
		rd_chk(ADDR_STAT1, 8'h00, "sr1 evf clr");
		bus_wr(ADDR_CTRL, 8'h35);
		$display("test master done");
		// Header flag needs status_two read before the data write
		pulse(10'h002, 8'h00);
		rd_chk(ADDR_STAT1, 8'hc0, "sr1 hdr");
		bus_wr(ADDR_DATA, 8'hf0);
		rd_chk(ADDR_STAT2, 8'h00, "sr2 hdr");
		bus_wr(ADDR_DATA, 8'h11);
		rd_chk(ADDR_STAT1, 8'h00, "sr1 hdr clr");
		// Clock enable low freezes state: the event is lost
		@(posedge clk);
		ce <= 1'b0;
		pulse(10'h004, 8'h00);
		@(posedge clk);
		ce <= 1'b1;
		rd_chk(ADDR_STAT2, 8'h00, "ce frozen");
		// Misplaced condition
		pulse(10'h004, 8'h00);
		rd_chk(ADDR_STAT1, 8'h80, "sr1 bus_error");
		rd_chk(ADDR_STAT2, 8'h02, "sr2 bus_error");
		rd_chk(ADDR_STAT2, 8'h00, "sr2 clr");
		$display("test header error done");
		// Slave frame with general call, ended by a stop
		isf_bus_partner_inst.bus_start();
		rd_chk(ADDR_STAT1, 8'h10, "busy");
		isf_bus_partner_inst.pulses(2);
		pulse(10'h0c0, 8'h00);
		chk1("hold own_address_hit", 1'b1, scl_oe);
		rd_chk(ADDR_STAT1, 8'h94, "sr1 own_address_hit");
		rd_chk(ADDR_STAT2, 8'h01, "sr2 general_call_seen");
		rd_chk(ADDR_STAT1, 8'h10, "own_address_hit clr");
		isf_bus_partner_inst.bus_stop();
		rd_chk(ADDR_STAT2, 8'h08, "sr2 stop_seen");
		rd_chk(ADDR_STAT1, 8'h00, "idle");
		$display("test slave frame done");
		// Disable clears all but busy, which keeps tracking the bus
		isf_bus_partner_inst.bus_start();
		pulse(10'h210, 8'h00);
		bus_wr(ADDR_CTRL, 8'h00);
		rd_chk(ADDR_STAT1, 8'h10, "sr1 off");
		rd_chk(ADDR_STAT2, 8'h00, "sr2 off");
		chk1("irq off", 1'b0, irq_o);
		pulse(10'h200, 8'h00);
		rd_chk(ADDR_STAT1, 8'h10, "ignored");
		isf_bus_partner_inst.bus_stop();
		rd_chk(ADDR_STAT1, 8'h00, "busy off");
		$display("test disable done");
		stop_test();
	end
endmodule // tb_isf_status_flags
